/* File: logic/iots_pkg.sv */
`default_nettype none

package iots_pkg;

  // ****************************************
  // Word and field layout
  // ****************************************
  localparam int WORD_W = 18;
  localparam int SELECT_W = 6;
  localparam int OPCODE_LSB = 14;
  localparam logic [3:0] OPCODE_TRANSFER = 4'h_e;
  localparam int SELECT_LSB = 6;
  localparam int PULSE_FIRST_BIT = 0;
  localparam int PULSE_SECOND_BIT = 1;
  localparam int PULSE_THIRD_BIT = 2;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_INSTR = 8'h_00;
  localparam logic [7:0] ADDR_ACC = 8'h_04;
  localparam logic [7:0] ADDR_STATUS = 8'h_08;
  localparam logic [7:0] ADDR_SLOW_DELAY = 8'h_0c;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h_10;
  localparam logic [7:0] ADDR_SAVED_ACC = 8'h_14;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;
  localparam int STAT_SLOW = 2;
  localparam int STAT_SERVICE = 3;
  localparam int STAT_PENDING = 4;
  localparam int INTC_ENABLE = 0;
  localparam int INTC_RESUME = 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int LEAD_NS = 1150;
  localparam int GAP12_NS = 450;
  localparam int GAP24_NS = 150;
  localparam int SLOW_MIN_NS = 1000;
  localparam int SLOW_MAX_NS = 4000;
  localparam int SLOW_CYCLE_NS = 3360;
  localparam logic [7:0] LEAD_CYC = 8'((LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] GAP12_CYC = 8'((GAP12_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] GAP24_CYC = 8'((GAP24_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SLOW_MIN_CYC = 8'((SLOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SLOW_MAX_CYC = 8'(SLOW_MAX_NS / CLK_PERIOD_NS);
  localparam logic [8:0] SLOW_CYCLE_CYC = 9'((SLOW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SETUP_CYC = 8'h_04;
  localparam logic [7:0] SLOW_DELAY_RESET = SLOW_MIN_CYC;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LEAD, SEQ_GAP1, SEQ_GAP2} iots_seq_type;

endpackage : iots_pkg

`default_nettype wire

/* File: logic/iots_link_if.sv */
`default_nettype none

interface iots_link_if (
  input wire logic clk,
  input wire logic reset_n
);
  logic io_transfer_instruction;
  logic [5:0] select_code;
  logic first_event_pulse;
  logic second_event_pulse;
  logic third_event_pulse;
  logic [17:0] output_distributor;
  logic [17:0] input_mixer;
  logic input_strobe;
  logic flag_level;
  logic skip_strobe;
  logic slow_request;
  logic interrupt_request;

  modport processor (
    output io_transfer_instruction, select_code, first_event_pulse, second_event_pulse,
    output third_event_pulse, output_distributor,
    input input_mixer, input_strobe, flag_level, skip_strobe, slow_request, interrupt_request
  );

  modport peripheral (
    input io_transfer_instruction, select_code, first_event_pulse, second_event_pulse,
    input third_event_pulse, output_distributor,
    output input_mixer, input_strobe, flag_level, skip_strobe, slow_request, interrupt_request
  );
endinterface : iots_link_if

`default_nettype wire

/* File: logic/iots_select_channel.sv */
`default_nettype none

module iots_select_channel #(
  parameter logic [5:0] SELECT_CODE = 6'h_1c,
  parameter logic SLOW_WIRED = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic io_transfer_instruction,
  input wire logic [5:0] select_code,
  input wire logic [2:0] event_pulses,
  output logic [2:0] command_pulses,
  output logic slow_request
);

  logic match;

  assign match = io_transfer_instruction && (select_code == SELECT_CODE);

  // ****************************************
  // Pulse regeneration
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      command_pulses <= 3'h_0;
    end else begin
      command_pulses <= event_pulses & {3{match}};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_request <= 1'b0;
    end else begin
      slow_request <= SLOW_WIRED && match;
    end
  end

endmodule : iots_select_channel

`default_nettype wire

/* File: logic/iots_peripheral.sv */
`default_nettype none

module iots_peripheral #(
  parameter logic [5:0] SELECT_CODE = 6'h_1c,
  parameter logic SLOW_WIRED = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  iots_link_if.peripheral link,
  input wire logic flag_in,
  input wire logic [17:0] data_in,
  output logic [17:0] data_out,
  output logic start_pulse
);

  logic [2:0] command;
  logic flag_reg;
  logic [17:0] mixer_reg;
  logic [17:0] data_out_reg;

  iots_select_channel #(
    .SELECT_CODE(SELECT_CODE),
    .SLOW_WIRED(SLOW_WIRED)
  ) channel (
    .clk(clk),
    .reset_n(reset_n),
    .io_transfer_instruction(link.io_transfer_instruction),
    .select_code(link.select_code),
    .event_pulses({link.third_event_pulse, link.second_event_pulse, link.first_event_pulse}),
    .command_pulses(command),
    .slow_request(link.slow_request)
  );

  // ****************************************
  // Flag, input data and output register
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
      mixer_reg <= 18'h_0_0000;
    end else begin
      flag_reg <= flag_in;
      mixer_reg <= data_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out_reg <= 18'h_0_0000;
    end else if (command[1]) begin
      data_out_reg <= link.output_distributor;
    end
  end

  assign link.flag_level = flag_reg;
  assign link.interrupt_request = flag_reg;
  assign link.skip_strobe = command[0];
  assign link.input_mixer = mixer_reg;
  assign link.input_strobe = command[1];
  assign data_out = data_out_reg;
  assign start_pulse = command[2];

endmodule : iots_peripheral

`default_nettype wire

/* File: logic/iots_processor.sv */
// Behaviour
// - All transfers go through the accumulator.
// - Opcode 1110 raises transfer-instruction signal.
// - Low three instruction bits select pulses.
// - One instruction yields up to three pulses.
// - Bits 6-11 bussed as select code.
// - Matching channel regenerates pulses; others silent.
// - Command named by low twelve bits.
// - Normal transfer cycle lasts 1.75 microseconds.
// - Selected channel may request slow timing.
// - Pulses at T5, T7, next T1.
// - Instruction held unchanged through next T1.
// - Gaps 450 ns then 150 ns normally.
// - Back to back: 1.15 us third-to-first.
// - Slow gaps adjustable 1 to 4 us.
// - One slow delay setting for all devices.
// - Slow cycle lasts at least 3.36 us.
// - Each pulse: transfer, bit, timing gate.
// - Each pulse reaches every selection channel.
// - Flag sampled by command pulse sets skip.
// - Peripheral strobes distributor data when commanded.
// - Gated input data enters accumulator.
// - Interrupt saves state, service, then resume.
//
// The register addresses and the APB interface to the registers were decided locally.
`default_nettype none

module iots_processor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  iots_link_if.processor link
);

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr == iots_pkg::ADDR_INSTR) || (addr == iots_pkg::ADDR_ACC) ||
                 (addr == iots_pkg::ADDR_STATUS) || (addr == iots_pkg::ADDR_SLOW_DELAY) ||
                 (addr == iots_pkg::ADDR_INT_CTRL) || (addr == iots_pkg::ADDR_SAVED_ACC);
  endfunction : reg_mapped

  function automatic logic is_transfer(input logic [17:0] word);
    is_transfer = word[17:iots_pkg::OPCODE_LSB] == iots_pkg::OPCODE_TRANSFER;
  endfunction : is_transfer

  // Lead to next first pulse, stretched so a slow cycle meets its minimum
  function automatic logic [7:0] lead_count(input logic slow, input logic [7:0] delay);
    logic [8:0] rest;
    rest = iots_pkg::SLOW_CYCLE_CYC - {delay, 1'b0};
    lead_count = iots_pkg::LEAD_CYC;
    if (slow && !rest[8] && (rest[7:0] > iots_pkg::LEAD_CYC)) begin
      lead_count = rest[7:0];
    end
  endfunction : lead_count

  iots_pkg::iots_seq_type seq_reg;
  logic [7:0] count_reg;
  logic [17:0] instr_reg;
  logic instr_valid_reg;
  logic iot_reg;
  logic [2:0] pulse_reg;
  logic [17:0] acc_reg;
  logic [17:0] saved_acc_reg;
  logic skip_reg;
  logic slow_reg;
  logic [7:0] slow_delay_reg;
  logic int_enable_reg;
  logic service_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic setup_phase;
  logic write_en;
  logic wr_instr;
  logic t5_evt;
  logic t7_evt;
  logic t1_evt;
  logic take_int;
  logic [7:0] gap_first;
  logic [7:0] gap_second;
  logic [31:0] read_next;
  logic [7:0] delay_wr;

  // ****************************************
  // APB slave
  // ****************************************
  assign setup_phase = psel && penable && !pready_reg;
  assign write_en = psel && penable && pready_reg && pwrite;
  assign wr_instr = write_en && (paddr == iots_pkg::ADDR_INSTR) && !instr_valid_reg &&
                    ((seq_reg == iots_pkg::SEQ_IDLE) ||
                     ((seq_reg == iots_pkg::SEQ_LEAD) && (count_reg >= iots_pkg::SETUP_CYC)));

  always_comb begin
    read_next = 32'h_0000_0000;
    case (paddr)
      iots_pkg::ADDR_INSTR: read_next = {14'h_0000, instr_reg};
      iots_pkg::ADDR_ACC: read_next = {14'h_0000, acc_reg};
      iots_pkg::ADDR_STATUS: begin
        read_next[iots_pkg::STAT_BUSY] = seq_reg != iots_pkg::SEQ_IDLE;
        read_next[iots_pkg::STAT_SKIP] = skip_reg;
        read_next[iots_pkg::STAT_SLOW] = slow_reg;
        read_next[iots_pkg::STAT_SERVICE] = service_reg;
        read_next[iots_pkg::STAT_PENDING] = instr_valid_reg;
      end
      iots_pkg::ADDR_SLOW_DELAY: read_next = {24'h_00_0000, slow_delay_reg};
      iots_pkg::ADDR_INT_CTRL: read_next[iots_pkg::INTC_ENABLE] = int_enable_reg;
      iots_pkg::ADDR_SAVED_ACC: read_next = {14'h_0000, saved_acc_reg};
      default: read_next = 32'h_0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h_0000_0000;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !reg_mapped(paddr);
      if (setup_phase && !pwrite) begin
        prdata_reg <= read_next;
      end
    end
  end

  // ****************************************
  // Slow delay setting
  // ****************************************
  assign delay_wr = (pwdata < 32'(iots_pkg::SLOW_MIN_CYC)) ? iots_pkg::SLOW_MIN_CYC :
                    (pwdata > 32'(iots_pkg::SLOW_MAX_CYC)) ? iots_pkg::SLOW_MAX_CYC : pwdata[7:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_delay_reg <= iots_pkg::SLOW_DELAY_RESET;
    end else if (write_en && (paddr == iots_pkg::ADDR_SLOW_DELAY)) begin
      slow_delay_reg <= delay_wr;
    end
  end

  // ****************************************
  // Time-state sequencer
  // ****************************************
  assign t5_evt = (seq_reg == iots_pkg::SEQ_LEAD) && (count_reg == 8'h_00) && instr_valid_reg;
  assign t7_evt = (seq_reg == iots_pkg::SEQ_GAP1) && (count_reg == 8'h_00);
  assign t1_evt = (seq_reg == iots_pkg::SEQ_GAP2) && (count_reg == 8'h_00);
  assign gap_first = link.slow_request ? slow_delay_reg : iots_pkg::GAP12_CYC;
  assign gap_second = slow_reg ? slow_delay_reg : iots_pkg::GAP24_CYC;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_reg <= iots_pkg::SEQ_IDLE;
      count_reg <= 8'h_00;
    end else begin
      unique case (seq_reg)
        iots_pkg::SEQ_IDLE: begin
          if (wr_instr || instr_valid_reg) begin
            seq_reg <= iots_pkg::SEQ_LEAD;
            count_reg <= iots_pkg::LEAD_CYC - 8'h_01;
          end
        end
        iots_pkg::SEQ_LEAD: begin
          if (count_reg != 8'h_00) begin
            count_reg <= count_reg - 8'h_01;
          end else if (instr_valid_reg) begin
            seq_reg <= iots_pkg::SEQ_GAP1;
            count_reg <= gap_first - 8'h_01;
          end else begin
            seq_reg <= iots_pkg::SEQ_IDLE;
          end
        end
        iots_pkg::SEQ_GAP1: begin
          if (count_reg != 8'h_00) begin
            count_reg <= count_reg - 8'h_01;
          end else begin
            seq_reg <= iots_pkg::SEQ_GAP2;
            count_reg <= gap_second - 8'h_01;
          end
        end
        iots_pkg::SEQ_GAP2: begin
          if (count_reg != 8'h_00) begin
            count_reg <= count_reg - 8'h_01;
          end else begin
            seq_reg <= iots_pkg::SEQ_LEAD;
            count_reg <= lead_count(slow_reg, slow_delay_reg) - 8'h_01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_reg <= 18'h_0_0000;
      instr_valid_reg <= 1'b0;
    end else if (wr_instr) begin
      instr_reg <= pwdata[17:0];
      instr_valid_reg <= 1'b1;
    end else if (t1_evt) begin
      instr_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_reg <= 1'b0;
    end else if (t5_evt) begin
      slow_reg <= link.slow_request;
    end
  end

  // ****************************************
  // Event pulse gates
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iot_reg <= 1'b0;
      pulse_reg <= 3'h_0;
    end else begin
      iot_reg <= instr_valid_reg && is_transfer(instr_reg);
      pulse_reg[0] <= iot_reg && instr_reg[iots_pkg::PULSE_FIRST_BIT] && t5_evt;
      pulse_reg[1] <= iot_reg && instr_reg[iots_pkg::PULSE_SECOND_BIT] && t7_evt;
      pulse_reg[2] <= iot_reg && instr_reg[iots_pkg::PULSE_THIRD_BIT] && t1_evt;
    end
  end

  // ****************************************
  // Accumulator, skip and interrupt
  // ****************************************
  assign take_int = int_enable_reg && link.interrupt_request && !service_reg &&
                    (seq_reg == iots_pkg::SEQ_IDLE) && !instr_valid_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= 18'h_0_0000;
    end else if (write_en && (paddr == iots_pkg::ADDR_INT_CTRL) && pwdata[iots_pkg::INTC_RESUME] && service_reg) begin
      acc_reg <= saved_acc_reg;
    end else begin
      acc_reg <= ((write_en && (paddr == iots_pkg::ADDR_ACC)) ? pwdata[17:0] : acc_reg) |
                 (link.input_strobe ? link.input_mixer : 18'h_0_0000);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_reg <= 1'b0;
    end else if (link.skip_strobe && link.flag_level) begin
      skip_reg <= 1'b1;
    end else if (write_en && (paddr == iots_pkg::ADDR_STATUS) && pwdata[iots_pkg::STAT_SKIP]) begin
      skip_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_enable_reg <= 1'b0;
      service_reg <= 1'b0;
      saved_acc_reg <= 18'h_0_0000;
    end else if (take_int) begin
      saved_acc_reg <= acc_reg;
      service_reg <= 1'b1;
      int_enable_reg <= 1'b0;
    end else if (write_en && (paddr == iots_pkg::ADDR_INT_CTRL)) begin
      int_enable_reg <= pwdata[iots_pkg::INTC_ENABLE];
      if (pwdata[iots_pkg::INTC_RESUME]) begin
        service_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign link.io_transfer_instruction = iot_reg;
  assign link.select_code = instr_reg[iots_pkg::SELECT_LSB +: iots_pkg::SELECT_W];
  assign link.first_event_pulse = pulse_reg[0];
  assign link.second_event_pulse = pulse_reg[1];
  assign link.third_event_pulse = pulse_reg[2];
  assign link.output_distributor = acc_reg;

endmodule : iots_processor

`default_nettype wire

/* File: test/iots_link_asserts.sv */
`default_nettype none

module iots_link_asserts #(
  parameter logic [5:0] SELECT_CODE = 6'h_1c,
  parameter logic SLOW_WIRED = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic io_transfer_instruction,
  input wire logic [5:0] select_code,
  input wire logic first_event_pulse,
  input wire logic second_event_pulse,
  input wire logic third_event_pulse,
  input wire logic [17:0] output_distributor,
  input wire logic [17:0] input_mixer,
  input wire logic input_strobe,
  input wire logic flag_level,
  input wire logic skip_strobe,
  input wire logic slow_request,
  input wire logic interrupt_request
);
  // **********
  // Pulse spacing counters
  // **********
  logic [7:0] since_first_reg;
  logic [7:0] since_second_reg;
  logic [7:0] since_third_reg;
  logic any_pulse;

  assign any_pulse = first_event_pulse || second_event_pulse || third_event_pulse;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) since_first_reg <= 8'h_ff;
    else if (first_event_pulse) since_first_reg <= 8'h_01;
    else if (since_first_reg != 8'h_ff) since_first_reg <= since_first_reg + 8'h_01;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) since_second_reg <= 8'h_ff;
    else if (second_event_pulse) since_second_reg <= 8'h_01;
    else if (since_second_reg != 8'h_ff) since_second_reg <= since_second_reg + 8'h_01;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) since_third_reg <= 8'h_ff;
    else if (third_event_pulse) since_third_reg <= 8'h_01;
    else if (since_third_reg != 8'h_ff) since_third_reg <= since_third_reg + 8'h_01;
  end

  // **********
  // Properties
  // **********
  sequence first_sel_s;
    first_event_pulse && select_code == SELECT_CODE;
  endsequence

  sequence second_sel_s;
    second_event_pulse && select_code == SELECT_CODE;
  endsequence

  gap_one_two_a: assert property (second_event_pulse && !slow_request && since_first_reg < 8'h_28 |->
    since_first_reg == 8'h_17) else $error("second pulse not 23 cycles after first");
  gap_two_three_a: assert property (third_event_pulse && !slow_request && since_second_reg < 8'h_28 |->
    since_second_reg == 8'h_08) else $error("third pulse not 8 cycles after second");
  gap_back_a: assert property (first_event_pulse && !slow_request |-> since_third_reg >= 8'h_3a)
    else $error("first pulse too soon after third");
  pulse_width_a: assert property (any_pulse |=> !any_pulse) else $error("event pulse wider than one cycle");
  pulse_gate_a: assert property (any_pulse |-> io_transfer_instruction)
    else $error("event pulse without transfer instruction");
  select_hold_a: assert property (any_pulse |-> $stable(select_code))
    else $error("select code changed during sequence");
  skip_cmd_a: assert property (first_sel_s |=> skip_strobe) else $error("first command pulse missing");
  input_cmd_a: assert property (second_sel_s |=> input_strobe) else $error("second command pulse missing");
  silent_chan_a: assert property (skip_strobe |-> $past(first_event_pulse) && $past(select_code) == SELECT_CODE)
    else $error("command pulse from unselected channel");
  slow_req_a: assert property (slow_request |-> SLOW_WIRED && select_code == SELECT_CODE)
    else $error("slow request from unwired channel");
  irq_follow_a: assert property (interrupt_request == flag_level)
    else $error("interrupt request differs from flag");
endmodule : iots_link_asserts

`default_nettype wire

/* File: test/test_io_transfer_pulse_sequencer.sv */
`default_nettype none

module test_io_transfer_pulse_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // **********
  // Harness
  // **********
  logic clk, reset_n, psel, penable, pwrite, flag_in, pready, pslverr, er, start_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, prdata_s, rd, rd_s;
  logic [17:0] data_in, data_out;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int skips = 0;
  int starts = 0;
  int s;
  int cnt[3] = '{0, 0, 0};
  int b[3];
  int stamp[3];
  int stamp_s[3];

  iots_link_if la (.clk(clk), .reset_n(reset_n));
  iots_link_if ls (.clk(clk), .reset_n(reset_n));
  wire logic [2:0] pa = {la.third_event_pulse, la.second_event_pulse, la.first_event_pulse};
  wire logic [2:0] ps = {ls.third_event_pulse, ls.second_event_pulse, ls.first_event_pulse};

  iots_processor iots_processor_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(la.processor));
  iots_processor iots_processor_slow_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s), .pready(), .pslverr(), .link(ls.processor));
  iots_peripheral #(.SELECT_CODE(6'h_1c)) iots_peripheral_inst (.clk(clk), .reset_n(reset_n),
    .link(la.peripheral), .flag_in(flag_in), .data_in(data_in), .data_out(data_out), .start_pulse(start_pulse));
  iots_peripheral #(.SELECT_CODE(6'h_1c), .SLOW_WIRED(1'b1)) iots_peripheral_slow_inst (.clk(clk),
    .reset_n(reset_n), .link(ls.peripheral), .flag_in(flag_in), .data_in(data_in), .data_out(), .start_pulse());
  iots_link_asserts #(.SELECT_CODE(6'h_1c), .SLOW_WIRED(1'b0)) iots_link_asserts_inst (.clk(clk),
    .reset_n(reset_n), .io_transfer_instruction(la.io_transfer_instruction), .select_code(la.select_code),
    .first_event_pulse(la.first_event_pulse), .second_event_pulse(la.second_event_pulse),
    .third_event_pulse(la.third_event_pulse), .output_distributor(la.output_distributor),
    .input_mixer(la.input_mixer), .input_strobe(la.input_strobe), .flag_level(la.flag_level),
    .skip_strobe(la.skip_strobe), .slow_request(la.slow_request), .interrupt_request(la.interrupt_request));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulse counts and cycle stamps, plus the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++) begin
      if (pa[i] === 1'b1) begin
        cnt[i] <= cnt[i] + 1;
        stamp[i] <= cyc;
      end
      if (ps[i] === 1'b1) stamp_s[i] <= cyc;
    end
    if (la.skip_strobe === 1'b1) skips <= skips + 1;
    if (start_pulse === 1'b1) starts <= starts + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  // **********
  // Tasks
  // **********
  task automatic conclude;
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rd_s = prdata_s;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h_0000_0000);
    check(rd, e);
  endtask : rdchk

  task automatic wait_idle;
    do apb(1'b0, iots_pkg::ADDR_STATUS, 32'h_0000_0000); while (((rd | rd_s) & 32'h_0000_0011) !== 32'h_0000_0000);
  endtask : wait_idle

  task automatic run(input logic [31:0] v);
    b = cnt;
    s = skips;
    apb(1'b1, iots_pkg::ADDR_INSTR, v);
    wait_idle();
  endtask : run

  function automatic logic [31:0] ins(input logic [3:0] op, input logic [5:0] code, input logic [2:0] m);
    return {14'h_0000, op, 2'b00, code, 3'b000, m};
  endfunction : ins

  // **********
  // Tests
  // **********
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, flag_in} = 4'h_0;
    paddr = 8'h_00;
    pwdata = 32'h_0000_0000;
    data_in = 18'h_0_0000;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(iots_pkg::ADDR_SLOW_DELAY, 32'(iots_pkg::SLOW_DELAY_RESET));
    rdchk(iots_pkg::ADDR_STATUS, 32'h_0000_0000);
    apb(1'b0, 8'h_20, 32'h_0000_0000);
    check({rd[30:0], er}, 32'h_0000_0001);
    for (int m = 1; m < 8; m++) begin
      run(ins(4'h_e, 6'h_1c, 3'(m)));
      for (int i = 0; i < 3; i++) check(cnt[i] - b[i], 32'(m[i]));
      check(skips - s, 32'(m[0]));
    end
    check(32'(starts), 32'h_0000_0004);
    check(stamp[1] - stamp[0], 32'h_0000_0017);
    check(stamp[2] - stamp[1], 32'h_0000_0008);
    check(32'(la.select_code), 32'h_0000_001c);
    run(ins(4'h_e, 6'h_05, 3'h_7));
    check(cnt[0] - b[0], 32'h_0000_0001);
    check(skips - s, 32'h_0000_0000);
    run(ins(4'h_d, 6'h_1c, 3'h_7));
    check(cnt[2] - b[2], 32'h_0000_0000);
    run(ins(4'h_e, 6'h_1c, 3'h_1) | 32'h_0000_3000);
    check(skips - s, 32'h_0000_0001);
    flag_in <= 1'b1;
    run(ins(4'h_e, 6'h_1c, 3'h_1));
    rdchk(iots_pkg::ADDR_STATUS, 32'h_0000_0002);
    apb(1'b1, iots_pkg::ADDR_STATUS, 32'h_0000_0002);
    rdchk(iots_pkg::ADDR_STATUS, 32'h_0000_0000);
    flag_in <= 1'b0;
    data_in <= 18'h_1_2300;
    apb(1'b1, iots_pkg::ADDR_ACC, 32'h_0000_00f0);
    run(ins(4'h_e, 6'h_1c, 3'h_2));
    check({14'h_0000, data_out}, 32'h_0000_00f0);
    rdchk(iots_pkg::ADDR_ACC, 32'h_0001_23f0);
    apb(1'b1, iots_pkg::ADDR_SLOW_DELAY, 32'h_0000_000a);
    rdchk(iots_pkg::ADDR_SLOW_DELAY, 32'h_0000_0032);
    apb(1'b1, iots_pkg::ADDR_SLOW_DELAY, 32'h_0000_0190);
    rdchk(iots_pkg::ADDR_SLOW_DELAY, 32'h_0000_00c8);
    apb(1'b1, iots_pkg::ADDR_SLOW_DELAY, 32'h_0000_003c);
    run(ins(4'h_e, 6'h_1c, 3'h_7));
    check(stamp_s[1] - stamp_s[0], 32'h_0000_003c);
    check(stamp_s[2] - stamp_s[1], 32'h_0000_003c);
    check(stamp[1] - stamp[0], 32'h_0000_0017);
    check(rd_s & 32'h_0000_0004, 32'h_0000_0004);
    apb(1'b1, iots_pkg::ADDR_INSTR, ins(4'h_e, 6'h_1c, 3'h_7));
    s = cnt[2];
    while (cnt[2] == s) @(posedge clk);
    s = cnt[0];
    apb(1'b1, iots_pkg::ADDR_INSTR, ins(4'h_e, 6'h_1c, 3'h_7));
    while (cnt[0] == s) @(posedge clk);
    check(stamp[0] - stamp[2], 32'h_0000_003a);
    wait_idle();
    apb(1'b1, iots_pkg::ADDR_ACC, 32'h_0000_0abc);
    flag_in <= 1'b1;
    apb(1'b1, iots_pkg::ADDR_INT_CTRL, 32'h_0000_0001);
    rdchk(iots_pkg::ADDR_STATUS, 32'h_0000_0008);
    rdchk(iots_pkg::ADDR_SAVED_ACC, 32'h_0000_0abc);
    apb(1'b1, iots_pkg::ADDR_ACC, 32'h_0000_0000);
    flag_in <= 1'b0;
    apb(1'b1, iots_pkg::ADDR_INT_CTRL, 32'h_0000_0002);
    rdchk(iots_pkg::ADDR_ACC, 32'h_0000_0abc);
    rdchk(iots_pkg::ADDR_STATUS, 32'h_0000_0000);
    conclude();
  end
endmodule : test_io_transfer_pulse_sequencer

`default_nettype wire
